// >>> pds_deadband.sv
`timescale 1ns/1ns
module pds_deadband (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Control
   input wire logic run,
   input wire logic enable,
   input wire logic [pds_pkg::DB_W-1:0] delay_count,
   // Waveform
   input wire logic sched_in,
   output logic out_level
);
   logic prev_in;                         // Last scheduled level
   logic [pds_pkg::DB_CNT_W-1:0] cnt;     // Remaining delay in mclk cycles
   logic rise;

   assign rise = sched_in & ~prev_in;

   // Instruction cycles to mclk cycles
   function automatic logic [pds_pkg::DB_CNT_W-1:0] db_load(input logic [pds_pkg::DB_W-1:0] c);
      db_load = pds_pkg::DB_CNT_W'(c) * pds_pkg::DB_CNT_W'(pds_pkg::TOSC_PER_TCY);
   endfunction

   // ----------------------------------------
   // Delay counter
   // ----------------------------------------
   // Falls pass at once; only rises wait, and each rise restarts the count
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prev_in <= 1'b0;
         cnt <= '0;
         out_level <= 1'b0;
      end else if (run) begin
         prev_in <= sched_in;
         if (!enable) begin
            out_level <= sched_in;
            cnt <= '0;
         end else if (!sched_in) begin
            out_level <= 1'b0;
            cnt <= '0;
         end else if (rise) begin
            cnt <= db_load(delay_count);
         end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
         end else begin
            out_level <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_armed_one;
      $rose(sched_in) && enable && run && delay_count == 7'h01;
   endsequence
   sequence s_hold;
      sched_in && enable && run && delay_count == 7'h01;
   endsequence
   chk_delay_exact: assert property (@(posedge mclk) disable iff (!rst_b)
      s_armed_one ##1 s_hold[*6] |-> out_level && !$past(out_level))
      else $error("dead band delay not four cycles per count");
   chk_fall_now: assert property (@(posedge mclk) disable iff (!rst_b)
      (run && enable && !sched_in) |=> !out_level)
      else $error("inactive edge was delayed");
   chk_zero_delay: assert property (@(posedge mclk) disable iff (!rst_b)
      (run && enable && $rose(sched_in) && delay_count == 7'h00) ##1 (run && sched_in)
      |=> out_level)
      else $error("zero count added delay");
endmodule

// >>> pds_pkg.sv
package pds_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [1:0] ADDR_ENH = 2'h0;    // Enhanced PWM control
   localparam logic [1:0] ADDR_STEER = 2'h1;  // Pulse steering control
   localparam logic [1:0] ADDR_SHUT = 2'h2;   // Shutdown flag and live status
   localparam int ENH_RESTART_BIT = 7;        // Auto restart enable
   localparam int STEER_SYNC_BIT = 4;         // Steering sync select
   localparam int SHUT_FLAG_BIT = 7;          // Shutdown event flag
   localparam int SHUT_HALT_BIT = 4;          // Outputs held in shutdown
   localparam logic [7:0] ENH_RESET = 8'h00;
   localparam logic [7:0] STEER_RESET = 8'h01;
   localparam logic [7:0] STEER_MASK = 8'h1f; // Top three bits unimplemented

   // ----------------------------------------
   // Modes and timing
   // ----------------------------------------
   localparam logic [1:0] CCP_PWM_SEL = 2'h3; // Mode bits 3:2 for PWM
   localparam logic [1:0] CFG_SINGLE = 2'h0;  // Single output, steerable
   localparam logic [1:0] CFG_HALF = 2'h2;    // Half bridge
   localparam int TOSC_PER_TCY = 4;           // Oscillator periods per instruction cycle
   localparam int DB_W = 7;                   // Dead band count width
   localparam int DB_CNT_W = 9;               // Counter width in mclk cycles

   // Power state from the clock manager
   typedef enum logic [3:0] {
      PWR_RUN = 4'b0001,
      PWR_PRIMARY_IDLE_STATE = 4'b0010,
      PWR_LP_RUN = 4'b0100,
      PWR_SLEEP = 4'b1000
   } pds_pwr_t;

   // Shutdown and restart sequence
   typedef enum logic [2:0] {
      RS_RUN = 3'b001,
      RS_SHUT = 3'b010,
      RS_WAIT = 3'b100
   } pds_rs_t;

   // Pin group driven toward the port logic
   typedef struct packed {
      logic [3:0] own;  // Pin taken from port control
      logic [3:0] oe;   // Driver enabled
      logic [3:0] val;  // Level driven
   } pds_pins_t;

   // Shutdown drive choice per pin pair
   typedef struct packed {
      logic [1:0] ac;
      logic [1:0] bd;
   } pds_shut_cfg_t;
endpackage

// >>> pds_switch_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Power switch drivers on the four pads
// ----------------------------------------
module pds_switch_model (
   // Clock
   input wire logic mclk,
   // Pins from the block and port fallback levels
   input wire pds_pkg::pds_pins_t pins,
   input wire logic [3:0] port_lvl,
   input wire logic bridge,
   // Pad levels and overlap count
   output logic [3:0] pad,
   output int shoot_cnt
);
   // ----------------------------------------
   // Pad resolution
   // ----------------------------------------
   // Owned pads with the driver off fall to the board pull-down; released pads show the port level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pad[i] = pins.own[i] ? (pins.oe[i] & pins.val[i]) : port_lvl[i];
      end
   end

   // ----------------------------------------
   // Bridge overlap watch
   // ----------------------------------------
   // Both switches of the A/B leg on together would short the supply
   initial shoot_cnt = 0;
   always @(posedge mclk) begin
      if (bridge && pad[1:0] == 2'h3) begin
         shoot_cnt <= shoot_cnt + 1;
      end
   end
endmodule

// >>> pds_top.sv
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
// Summary of operation
// - Dead band only on inactive-to-active edges
// - Seven-bit count in instruction cycles
// - Active edge delayed count cycles plus one mclk
// - Auto restart clears flag when event ends
// - Waveform steerable to any pin combination
// - Steering only in single-output PWM mode
// - Enable bit routes waveform, else port
// - Low mode bits set steered polarity
// - Shutdown forces only pins taken from port
// - Sync clear: steering changes at once
// - Sync set: steering waits period start
// - Period starts when timer meets match
// - Sleep freezes state and holds outputs
// - Idle keeps clock; low power retimes timer
// - Steering register top bits read zero
// - Flag stays set while condition persists
// - Restart resumes at next period start
module pds_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   // PWM core side
   input wire logic pwm_raw,
   input wire logic [7:0] period_timer,
   input wire logic [7:0] period_match_value,
   input wire logic [3:0] ccp_mode_bits,
   input wire logic [1:0] output_config_bits,
   // Shutdown side
   input wire logic shutdown_cond,
   input wire pds_pkg::pds_shut_cfg_t shut_cfg,
   // Power management
   input wire pds_pkg::pds_pwr_t power_state,
   output logic timer_count_en,
   output logic timer_lp_clk_sel,
   // Pins
   output pds_pkg::pds_pins_t pins
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] enhanced_pwm_control;   // Restart enable and dead band count
   logic [7:0] pulse_steering_control; // Sync select and enables as written
   logic [3:0] active_steer;           // Enables now in force
   logic shutdown_event_flag;          // Sticky shutdown status
   pds_pkg::pds_rs_t rs_state;         // Restart sequence
   pds_pkg::pds_rs_t next_rs_state;
   pds_pkg::pds_pins_t next_pins;
   logic match_q;                      // Timer match seen last cycle
   logic run;                          // High outside sleep
   logic match;
   logic period_start;
   logic pwm_sel;
   logic half_mode;
   logic steer_mode;
   logic halted;
   logic wr_enh;
   logic wr_steer;
   logic wr_shut;
   logic flag_set;
   logic flag_clr;
   logic db_a;
   logic db_b;
   logic [7:0] next_rd;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign run = (power_state != pds_pkg::PWR_SLEEP);
   assign match = (period_timer == period_match_value);
   assign period_start = run & match & ~match_q;
   assign pwm_sel = (ccp_mode_bits[3:2] == pds_pkg::CCP_PWM_SEL);
   assign half_mode = pwm_sel & (output_config_bits == pds_pkg::CFG_HALF);
   assign steer_mode = pwm_sel & (output_config_bits == pds_pkg::CFG_SINGLE);
   assign halted = (rs_state != pds_pkg::RS_RUN);
   assign wr_enh = wr_stb & (reg_addr == pds_pkg::ADDR_ENH);
   assign wr_steer = wr_stb & (reg_addr == pds_pkg::ADDR_STEER);
   assign wr_shut = wr_stb & (reg_addr == pds_pkg::ADDR_SHUT);

   // Shutdown level for one pin: bit 1 tri-states the driver, bit 0 level
   function automatic logic [1:0] shut_drive(input logic [1:0] cfg);
      shut_drive = cfg[1] ? 2'b00 : {1'b1, cfg[0]};
   endfunction

   // ----------------------------------------
   // Period edge
   // ----------------------------------------
   // Timer may rest on the match value for several prescaled cycles
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         match_q <= 1'b0;
      end else if (run) begin
         match_q <= match;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Enhanced control is plain storage
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         enhanced_pwm_control <= pds_pkg::ENH_RESET;
      end else if (wr_enh) begin
         enhanced_pwm_control <= wr_data;
      end
   end

   // Steering register keeps unimplemented bits at zero
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pulse_steering_control <= pds_pkg::STEER_RESET;
      end else if (wr_steer) begin
         pulse_steering_control <= wr_data & pds_pkg::STEER_MASK;
      end
   end

   // Enables in force: at once, or at the next period edge
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         active_steer <= pds_pkg::STEER_RESET[3:0];
      end else if (wr_steer && !wr_data[pds_pkg::STEER_SYNC_BIT]) begin
         active_steer <= wr_data[3:0];
      end else if (period_start && pulse_steering_control[pds_pkg::STEER_SYNC_BIT]) begin
         active_steer <= pulse_steering_control[3:0];
      end
   end

   // ----------------------------------------
   // Shutdown flag
   // ----------------------------------------
   // Set wins over any clear; writes cannot clear a live condition
   assign flag_set = shutdown_cond | (wr_shut & wr_data[pds_pkg::SHUT_FLAG_BIT]);
   assign flag_clr = ~shutdown_cond &
      (enhanced_pwm_control[pds_pkg::ENH_RESTART_BIT] |
       (wr_shut & ~wr_data[pds_pkg::SHUT_FLAG_BIT]));

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         shutdown_event_flag <= 1'b0;
      end else if (run) begin
         if (flag_set) begin
            shutdown_event_flag <= 1'b1;
         end else if (flag_clr) begin
            shutdown_event_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Restart sequence
   // ----------------------------------------
   always_comb begin
      next_rs_state = rs_state;
      case (rs_state)
         pds_pkg::RS_RUN: begin
            if (shutdown_event_flag) next_rs_state = pds_pkg::RS_SHUT;
         end
         pds_pkg::RS_SHUT: begin
            if (!shutdown_event_flag) next_rs_state = pds_pkg::RS_WAIT;
         end
         pds_pkg::RS_WAIT: begin
            // Resume only on a whole period
            if (shutdown_event_flag) begin
               next_rs_state = pds_pkg::RS_SHUT;
            end else if (period_start) begin
               next_rs_state = pds_pkg::RS_RUN;
            end
         end
         default: next_rs_state = pds_pkg::RS_SHUT;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rs_state <= pds_pkg::RS_RUN;
      end else if (run) begin
         rs_state <= next_rs_state;
      end
   end

   // ----------------------------------------
   // Dead band, one per half-bridge output
   // ----------------------------------------
   pds_deadband u_db_a (
      .mclk(mclk),
      .rst_b(rst_b),
      .run(run),
      .enable(half_mode),
      .delay_count(enhanced_pwm_control[pds_pkg::DB_W-1:0]),
      .sched_in(pwm_raw),
      .out_level(db_a)
   );

   pds_deadband u_db_b (
      .mclk(mclk),
      .rst_b(rst_b),
      .run(run),
      .enable(half_mode),
      .delay_count(enhanced_pwm_control[pds_pkg::DB_W-1:0]),
      .sched_in(~pwm_raw),
      .out_level(db_b)
   );

   // ----------------------------------------
   // Pin steering
   // ----------------------------------------
   // Pins A and C share the first pair's polarity and shutdown choice
   always_comb begin
      next_pins = '0;
      for (int i = 0; i < 4; i++) begin
         if (steer_mode) begin
            next_pins.own[i] = active_steer[i];
            next_pins.oe[i] = active_steer[i];
            next_pins.val[i] = pwm_raw ^ (i[0] ? ccp_mode_bits[0] : ccp_mode_bits[1]);
         end else if (half_mode && i < 2) begin
            next_pins.own[i] = 1'b1;
            next_pins.oe[i] = 1'b1;
            next_pins.val[i] = i[0] ? (db_b ^ ccp_mode_bits[0]) : (db_a ^ ccp_mode_bits[1]);
         end
         // Only pins taken from the port see the shutdown level
         if (halted && next_pins.own[i]) begin
            {next_pins.oe[i], next_pins.val[i]} = shut_drive(i[0] ? shut_cfg.bd : shut_cfg.ac);
         end
      end
   end

   // Outputs hold their last value through sleep
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pins <= '0;
      end else if (run) begin
         pins <= next_pins;
      end
   end

   // ----------------------------------------
   // Power management
   // ----------------------------------------
   // Clock choice for the period timer is made outside; this only asks for it
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         timer_count_en <= 1'b0;
         timer_lp_clk_sel <= 1'b0;
      end else begin
         timer_count_en <= run;
         timer_lp_clk_sel <= (power_state == pds_pkg::PWR_LP_RUN);
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      next_rd = 8'h00;
      case (reg_addr)
         pds_pkg::ADDR_ENH: next_rd = enhanced_pwm_control;
         pds_pkg::ADDR_STEER: next_rd = pulse_steering_control & pds_pkg::STEER_MASK;
         pds_pkg::ADDR_SHUT: begin
            next_rd[pds_pkg::SHUT_FLAG_BIT] = shutdown_event_flag;
            next_rd[pds_pkg::SHUT_HALT_BIT] = halted;
            next_rd[3:0] = active_steer;
         end
         default: next_rd = 8'h00;
      endcase
   end

   // Data stand one cycle, zero otherwise
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_stb ? next_rd : 8'h00;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_steer_gate: assert property (@(posedge mclk) disable iff (!rst_b)
      (run && !steer_mode && !half_mode) |=> pins.own == 4'h0)
      else $error("pins taken outside steering mode");
   chk_steer_route: assert property (@(posedge mclk) disable iff (!rst_b)
      (rst_b && run && steer_mode) |=> pins.own == $past(active_steer))
      else $error("steered pins differ from enables");
   chk_steer_pol: assert property (@(posedge mclk) disable iff (!rst_b)
      (run && steer_mode && !halted && active_steer[2]) |=>
      pins.val[2] == ($past(pwm_raw) ^ $past(ccp_mode_bits[1])))
      else $error("steered polarity wrong");
   chk_shut_pins: assert property (@(posedge mclk) disable iff (!rst_b)
      (run && steer_mode && halted && !active_steer[1]) |=> !pins.own[1] && !pins.oe[1])
      else $error("shutdown touched a port pin");
   chk_sync_now: assert property (@(posedge mclk) disable iff (!rst_b)
      (wr_steer && !wr_data[4]) |=> active_steer == $past(wr_data[3:0]))
      else $error("immediate steering not applied");
   chk_sync_wait: assert property (@(posedge mclk) disable iff (!rst_b)
      (wr_steer && wr_data[4] && !period_start) |=> $stable(active_steer))
      else $error("deferred steering applied early");
   chk_auto_clear: assert property (@(posedge mclk) disable iff (!rst_b)
      (run && enhanced_pwm_control[7] && !shutdown_cond && !wr_shut) |=> !shutdown_event_flag)
      else $error("auto restart left flag set");
   chk_flag_holds: assert property (@(posedge mclk) disable iff (!rst_b)
      (run && shutdown_cond) |=> shutdown_event_flag)
      else $error("flag cleared during condition");
   chk_resume_edge: assert property (@(posedge mclk) disable iff (!rst_b)
      (rs_state == pds_pkg::RS_WAIT && !period_start) |=> rs_state != pds_pkg::RS_RUN)
      else $error("restart before period start");
   chk_sleep_freeze: assert property (@(posedge mclk) disable iff (!rst_b)
      (!run ##1 !run) |-> $stable(pins) && $stable(rs_state))
      else $error("state moved in sleep");
   chk_read_zero: assert property (@(posedge mclk) disable iff (!rst_b)
      (rd_stb && reg_addr == pds_pkg::ADDR_STEER) |=> rd_data[7:5] == 3'h0)
      else $error("unimplemented steering bits read nonzero");
endmodule

// >>> pds_top_tb.sv
`timescale 1ns/1ns
module pds_top_tb;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] wr_data = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [7:0] rd_data;
   logic pwm_raw = 1'b0;
   logic [7:0] period_timer = 8'h00;
   logic [7:0] period_match_value = 8'h10;
   logic [3:0] ccp_mode_bits = 4'hc;
   logic [1:0] output_config_bits = 2'h0;
   logic shutdown_cond = 1'b0;
   pds_pkg::pds_shut_cfg_t shut_cfg = 4'h4; // A/C drive 1, B/D drive 0
   pds_pkg::pds_pwr_t power_state = pds_pkg::PWR_RUN;
   logic timer_count_en;
   logic timer_lp_clk_sel;
   pds_pkg::pds_pins_t pins;
   logic [3:0] pad;
   logic bridge = 1'b0;
   int shoot_cnt;
   int errors = 0;
   int cmp_count = 0;
   int n;
   logic [7:0] v;
   logic [11:0] hold;
   // Settings that must leave the pins to the port
   logic [5:0] off_cfg [3] = '{6'h31, 6'h33, 6'h20};
   // Power states after sleep and the timer controls expected there
   pds_pkg::pds_pwr_t pwr_tab [3] =
      '{pds_pkg::PWR_PRIMARY_IDLE_STATE, pds_pkg::PWR_LP_RUN, pds_pkg::PWR_RUN};
   logic [1:0] pwr_exp [3] = '{2'h2, 2'h3, 2'h2};
   // Dead band counts, zero included
   int db_tab [3] = '{0, 1, 5};

   always #5 mclk = ~mclk;

   pds_top pds_top_i (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .pwm_raw(pwm_raw),
      .period_timer(period_timer), .period_match_value(period_match_value),
      .ccp_mode_bits(ccp_mode_bits), .output_config_bits(output_config_bits),
      .shutdown_cond(shutdown_cond), .shut_cfg(shut_cfg), .power_state(power_state),
      .timer_count_en(timer_count_en), .timer_lp_clk_sel(timer_lp_clk_sel), .pins(pins));

   pds_switch_model pds_switch_model_i (.mclk(mclk), .pins(pins), .port_lvl(4'ha),
      .bridge(bridge), .pad(pad), .shoot_cnt(shoot_cnt));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   // Compare and count
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Verdict and end of run
   task automatic summarize();
      if (errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Settle point just after an edge
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   // One-cycle register write
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask

   // One-cycle read, data taken in the following cycle only
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 d = rd_data;
   endtask

   // Timer meets the match value for one cycle
   task automatic period_start();
      @(posedge mclk) period_timer <= period_match_value;
      @(posedge mclk) period_timer <= 8'h00;
   endtask

   // Bounded wait for a pin pattern, then compare
   task automatic wait_pin(input logic [11:0] mask, input logic [11:0] exp);
      for (int i = 0; i < 12 && ({pins} & mask) !== exp; i++) begin
         cyc(1);
      end
      chk({pins} & mask, exp);
   endtask

   // Count edges until a pin level shows; limit guards a hang
   task automatic meas(input int idx, input logic lvl, inout int cnt);
      while (pins.val[idx] !== lvl && cnt < 600) begin
         cyc(1);
         cnt++;
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      // Reset values, unimplemented bits, unmapped slot
      rd(pds_pkg::ADDR_ENH, v);
      chk(12'(v), 12'(pds_pkg::ENH_RESET));
      rd(pds_pkg::ADDR_STEER, v);
      chk(12'(v), 12'(pds_pkg::STEER_RESET));
      rd(pds_pkg::ADDR_SHUT, v);
      chk(12'(v), 12'h001);
      wr(pds_pkg::ADDR_STEER, 8'hff);
      rd(pds_pkg::ADDR_STEER, v);
      chk(12'(v), 12'h01f);
      wr(pds_pkg::ADDR_ENH, 8'hff);
      rd(pds_pkg::ADDR_ENH, v);
      chk(12'(v), 12'h0ff);
      wr(2'h3, 8'haa);
      rd(2'h3, v);
      chk(12'(v), 12'h000);
      wr(pds_pkg::ADDR_ENH, 8'h00);
      // Immediate steering onto all four pins
      wr(pds_pkg::ADDR_STEER, 8'h0f);
      cyc(2);
      chk({pins} & 12'hf0f, 12'hf00);
      @(posedge mclk) pwm_raw <= 1'b1;
      // Pair polarity, every combination
      for (int m = 0; m < 4; m++) begin
         @(posedge mclk) ccp_mode_bits <= {2'h3, 2'(m)};
         cyc(1);
         chk(12'(pins.val), 12'({~m[0], ~m[1], ~m[0], ~m[1]}));
      end
      // Configurations where steering has no effect
      foreach (off_cfg[i]) begin
         @(posedge mclk) {ccp_mode_bits, output_config_bits} <= off_cfg[i];
         cyc(1);
         chk(12'(pins.own), 12'h000);
      end
      @(posedge mclk) {ccp_mode_bits, output_config_bits} <= 6'h30;
      // Synchronised change waits for the period start
      wr(pds_pkg::ADDR_STEER, 8'h11);
      cyc(5);
      chk(12'(pins.own), 12'h00f);
      period_start();
      wait_pin(12'hf00, 12'h100);
      chk(12'(pad), 12'h00b);
      // Sleep freezes pins; other states steer the timer clock
      @(posedge mclk) power_state <= pds_pkg::PWR_SLEEP;
      cyc(2);
      hold = {pins};
      @(posedge mclk) pwm_raw <= 1'b0;
      cyc(4);
      chk({pins}, hold);
      chk(12'({timer_count_en, timer_lp_clk_sel}), 12'h000);
      for (int s = 0; s < 3; s++) begin
         @(posedge mclk) power_state <= pwr_tab[s];
         cyc(2);
         chk(12'({timer_count_en, timer_lp_clk_sel}), 12'(pwr_exp[s]));
      end
      wait_pin(12'h001, 12'h000);
      // Shutdown with software restart
      wr(pds_pkg::ADDR_STEER, 8'h01);
      @(posedge mclk) shutdown_cond <= 1'b1;
      wait_pin(12'hf01, 12'h101);
      rd(pds_pkg::ADDR_SHUT, v);
      chk(12'(v), 12'h091);
      wr(pds_pkg::ADDR_SHUT, 8'h00);
      @(posedge mclk) shutdown_cond <= 1'b0;
      cyc(10);
      rd(pds_pkg::ADDR_SHUT, v);
      chk(12'(v[7]), 12'h001);
      wr(pds_pkg::ADDR_SHUT, 8'h00);
      cyc(6);
      chk(12'(pins.val[0]), 12'h001);
      period_start();
      wait_pin(12'h001, 12'h000);
      // Shutdown with automatic restart
      wr(pds_pkg::ADDR_ENH, 8'h80);
      @(posedge mclk) shutdown_cond <= 1'b1;
      wait_pin(12'h001, 12'h001);
      @(posedge mclk) shutdown_cond <= 1'b0;
      cyc(4);
      rd(pds_pkg::ADDR_SHUT, v);
      chk(12'(v[7]), 12'h000);
      period_start();
      wait_pin(12'h001, 12'h000);
      // Half bridge dead band on rising edges only
      @(posedge mclk) output_config_bits <= pds_pkg::CFG_HALF;
      bridge <= 1'b1;
      foreach (db_tab[i]) begin
         wr(pds_pkg::ADDR_ENH, 8'(db_tab[i]));
         cyc(30);
         @(posedge mclk) pwm_raw <= 1'b1;
         n = 0;
         meas(1, 1'b0, n);
         chk(12'(n), 12'h002);
         meas(0, 1'b1, n);
         chk(12'(n), 12'(3 + 4 * db_tab[i]));
         cyc(40);
         @(posedge mclk) pwm_raw <= 1'b0;
         n = 0;
         meas(0, 1'b0, n);
         chk(12'(n), 12'h002);
         meas(1, 1'b1, n);
         chk(12'(n), 12'(3 + 4 * db_tab[i]));
      end
      // Pulse shorter than the delay never reaches the pin
      @(posedge mclk) pwm_raw <= 1'b1;
      cyc(3);
      @(posedge mclk) pwm_raw <= 1'b0;
      n = 0;
      repeat (40) begin
         cyc(1);
         n += int'(pins.val[0] === 1'b1);
      end
      chk(12'(n), 12'h000);
      chk(12'(shoot_cnt), 12'h000);
      summarize();
   end

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   // Whole run needs a few hundred cycles; this is far beyond
   initial begin
      #200000;
      errors++;
      summarize();
   end
endmodule
